// *** rtl/clb_core.v ***
// Functional notes
// - protected config writable only while even table off
// - protected fields accepted with enable-zero, not one
// - global enable bit turns block on/off
// - per-table enable bit in first control register
// - output is pattern bit indexed by inputs
// - switched-off input reads as low
// - feedback input takes pair sequencer output
// - link input takes next table output, wrapping
// - pin option connects dedicated input pin
// - event signals selectable as table inputs
// - default combinational; resample delays two edges
// - filter passes stable values, four edge delay
// - filter state cleared after table disable
// - rise pulse on filtered output when enabled
// - edge detector cleared after table disable
// - pair function select picks sequencer function
// - sequencer fed from processed table outputs
// - sequencer uses even table clock
// - sequencer updates on edge, cleared when disabled
// - gated flop: even data, odd gate
// - toggle flop: hold, clear, set, toggle
// - gated latch follows data while gate high
// - set-clear latch, both high holds
// - clock select one: input two clocks, reads low
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "clb_defines.vh"

module clb_core (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [11:0] lut_pin_in,
  input  wire [3:0]  event_a,
  input  wire [3:0]  event_b,
  input  wire        ac_out,
  input  wire [1:0]  usart_txd,
  input  wire        spi_mosi,
  input  wire        spi_sck,
  input  wire [2:0]  tca_wo,
  input  wire [1:0]  tcb_wo,
  output wire [3:0]  lut_out
);

  // ****************************************
  // input source selection
  // ****************************************
  function pick;
    input [3:0] s;
    input       fb;
    input       lk;
    input       ea;
    input       eb;
    input       io;
    input       ac;
    input       us;
    input       sp;
    input       ta;
    input       tb;
    begin
      case (s)
        `CLB_IN_FEEDBACK: pick = fb;
        `CLB_IN_LINK:     pick = lk;
        `CLB_IN_EVENT_A:  pick = ea;
        `CLB_IN_EVENT_B:  pick = eb;
        `CLB_IN_PIN:      pick = io;
        `CLB_IN_AC:       pick = ac;
        `CLB_IN_USART:    pick = us;
        `CLB_IN_SPI:      pick = sp;
        `CLB_IN_TCA:      pick = ta;
        `CLB_IN_TCB:      pick = tb;
        default:          pick = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // state
  // ****************************************
  reg         awready_ff;
  reg         wready_ff;
  reg         bvalid_ff;
  reg  [1:0]  bresp_ff;
  reg         arready_ff;
  reg         rvalid_ff;
  reg  [1:0]  rresp_ff;
  reg  [31:0] rdata_ff;
  reg         have_aw_ff;
  reg         have_w_ff;
  reg  [5:0]  widx_ff;
  reg  [7:0]  wdat_ff;
  reg         wlane_ff;
  reg  [7:0]  glob_ff;
  reg  [3:0]  seq_ff [0:1];
  reg  [7:0]  cta_ff [0:3];
  reg  [7:0]  ctb_ff [0:3];
  reg  [3:0]  ctc_ff [0:3];
  reg  [7:0]  tru_ff [0:3];
  reg  [29:0] sync1_ff;
  reg  [29:0] sync2_ff;
  reg  [3:0]  direct_ff;
  reg  [3:0]  lut_out_ff;

  wire [3:0]  proc_w;
  wire [3:0]  ce_w;
  wire [3:0]  en_w;
  wire [3:0]  outen_w;
  wire [1:0]  seq_w;
  reg  [3:0]  out_w;
  reg  [31:0] rd_data;
  reg         rd_err;
  reg         wr_err;
  reg         prot_ok;
  integer     i;

  wire [29:0] raw_in = {tcb_wo, tca_wo, spi_sck, spi_mosi, usart_txd,
                        ac_out, event_b, event_a, lut_pin_in};
  wire [2:0]  us3    = {1'b0, sync2_ff[22:21]};
  wire [2:0]  tb3    = {1'b0, sync2_ff[29:28]};
  wire        aw_hs  = s_axi_awvalid & awready_ff;
  wire        w_hs   = s_axi_wvalid & wready_ff;
  wire        ar_hs  = s_axi_arvalid & arready_ff;
  wire        wr_go  = have_aw_ff & have_w_ff & ~bvalid_ff;
  wire [5:0]  ridx   = s_axi_araddr[7:2];
  wire [5:0]  roff   = ridx - `CLB_IDX_LUT_BASE;
  wire [5:0]  woff   = widx_ff - `CLB_IDX_LUT_BASE;
  wire [1:0]  wn     = woff[3:2];

  assign s_axi_awready = awready_ff;
  assign s_axi_wready  = wready_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign lut_out       = lut_out_ff;

  // ****************************************
  // input synchroniser
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      sync1_ff <= 30'h0;
      sync2_ff <= 30'h0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end

  // ****************************************
  // axi write channel
  // ****************************************
  always @* begin
    wr_err  = 1'b0;
    prot_ok = ~cta_ff[{wn[1], 1'b0}][`CLB_EN_BIT];
    if (widx_ff == `CLB_IDX_SEQ0 || widx_ff == `CLB_IDX_SEQ1) begin
      prot_ok = ~cta_ff[{widx_ff[1], 1'b0}][`CLB_EN_BIT];
    end else if (widx_ff != `CLB_IDX_GLOBAL && widx_ff != `CLB_IDX_STATUS
                 && (widx_ff < `CLB_IDX_LUT_BASE || widx_ff > `CLB_IDX_LUT_END)) begin
      wr_err = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `CLB_RESP_OKAY;
      have_aw_ff <= 1'b0;
      have_w_ff  <= 1'b0;
      widx_ff    <= 6'h0;
      wdat_ff    <= `CLB_RST_BYTE;
      wlane_ff   <= 1'b0;
    end else begin
      if (aw_hs) begin
        widx_ff    <= s_axi_awaddr[7:2];
        have_aw_ff <= 1'b1;
        awready_ff <= 1'b0;
      end
      if (w_hs) begin
        wdat_ff   <= s_axi_wdata[7:0];
        wlane_ff  <= s_axi_wstrb[0];
        have_w_ff <= 1'b1;
        wready_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_err ? `CLB_RESP_SLVERR : `CLB_RESP_OKAY;
        have_aw_ff <= 1'b0;
        have_w_ff  <= 1'b0;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff  <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff  <= 1'b1;
      end
    end
  end

  // ****************************************
  // configuration registers
  // ****************************************
  always @(posedge aclk) begin
    if (!aresetn) begin
      glob_ff <= `CLB_RST_BYTE;
      for (i = 0; i < 2; i = i + 1) begin
        seq_ff[i] <= `CLB_RST_NIBBLE;
      end
      for (i = 0; i < 4; i = i + 1) begin
        cta_ff[i] <= `CLB_RST_BYTE;
        ctb_ff[i] <= `CLB_RST_BYTE;
        ctc_ff[i] <= `CLB_RST_NIBBLE;
        tru_ff[i] <= `CLB_RST_BYTE;
      end
    end else if (wr_go && wlane_ff && !wr_err) begin
      if (widx_ff == `CLB_IDX_GLOBAL) begin
        glob_ff <= wdat_ff & `CLB_GLOBAL_MASK;
      end else if (widx_ff == `CLB_IDX_SEQ0 || widx_ff == `CLB_IDX_SEQ1) begin
        if (prot_ok) begin
          seq_ff[widx_ff[1]] <= wdat_ff[3:0];
        end
      end else if (widx_ff != `CLB_IDX_STATUS) begin
        case (woff[1:0])
          2'h0: begin
            if (prot_ok) begin
              cta_ff[wn] <= wdat_ff;
            end else begin
              cta_ff[wn] <= {cta_ff[wn][7:1], wdat_ff[`CLB_EN_BIT]};
            end
          end
          2'h1: begin
            if (prot_ok) begin
              ctb_ff[wn] <= wdat_ff;
            end
          end
          2'h2: begin
            if (prot_ok) begin
              ctc_ff[wn] <= wdat_ff[3:0];
            end
          end
          default: begin
            if (prot_ok) begin
              tru_ff[wn] <= wdat_ff;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // axi read channel
  // ****************************************
  always @* begin
    rd_data = 32'h0;
    rd_err  = 1'b0;
    if (ridx == `CLB_IDX_GLOBAL) begin
      rd_data = {24'h0, glob_ff};
    end else if (ridx == `CLB_IDX_SEQ0 || ridx == `CLB_IDX_SEQ1) begin
      rd_data = {28'h0, seq_ff[ridx[1]]};
    end else if (ridx == `CLB_IDX_STATUS) begin
      rd_data = {26'h0, seq_w, direct_ff};
    end else if (ridx >= `CLB_IDX_LUT_BASE && ridx <= `CLB_IDX_LUT_END) begin
      case (roff[1:0])
        2'h0:    rd_data = {24'h0, cta_ff[roff[3:2]]};
        2'h1:    rd_data = {24'h0, ctb_ff[roff[3:2]]};
        2'h2:    rd_data = {28'h0, ctc_ff[roff[3:2]]};
        default: rd_data = {24'h0, tru_ff[roff[3:2]]};
      endcase
    end else begin
      rd_err = 1'b1;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rresp_ff   <= `CLB_RESP_OKAY;
      rdata_ff   <= 32'h0;
    end else if (ar_hs) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rresp_ff   <= rd_err ? `CLB_RESP_SLVERR : `CLB_RESP_OKAY;
      rdata_ff   <= rd_data;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff  <= 1'b0;
      arready_ff <= 1'b1;
    end
  end

  // ****************************************
  // look-up tables
  // ****************************************
  genvar n;
  genvar y;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_lut
      wire [7:0]  ca      = cta_ff[n];
      wire [11:0] sels    = {ctc_ff[n], ctb_ff[n]};
      wire [2:0]  sel_in;
      wire        pin_clk = (ca[`CLB_CLKSEL_HI:`CLB_CLKSEL_LO] == `CLB_CLK_INPUT_TWO);
      wire [1:0]  cond    = ca[`CLB_COND_HI:`CLB_COND_LO];
      wire        en      = glob_ff[`CLB_EN_BIT] & ca[`CLB_EN_BIT];
      wire [2:0]  tidx;
      wire        raw;
      wire        filt;
      reg         in2_q_ff;
      reg         s1_ff;
      reg         s2_ff;
      reg         s3_ff;
      reg         flt_ff;
      reg         prev_ff;

      for (y = 0; y < 3; y = y + 1) begin : g_in
        assign sel_in[y] = pick(sels[4*y+3:4*y], seq_w[n/2], direct_ff[(n+1)%4],
                                sync2_ff[12+n], sync2_ff[16+n], sync2_ff[3*n+y],
                                sync2_ff[20], us3[y],
                                (y == 2) ? sync2_ff[24] : sync2_ff[23],
                                sync2_ff[25+y], tb3[y]);
      end

      assign tidx = {sel_in[2] & ~pin_clk, sel_in[1:0]};
      assign raw  = ca[0] ? tru_ff[n][tidx] : 1'b0;

      // table clock: every aclk, or rising edge of input two
      assign ce_w[n] = pin_clk ? (sel_in[2] & ~in2_q_ff) : 1'b1;

      always @(posedge aclk) begin
        if (!aresetn) begin
          in2_q_ff <= 1'b0;
        end else begin
          in2_q_ff <= sel_in[2];
        end
      end

      always @(posedge aclk) begin
        if (!aresetn || !en) begin
          s1_ff   <= 1'b0;
          s2_ff   <= 1'b0;
          s3_ff   <= 1'b0;
          flt_ff  <= 1'b0;
          prev_ff <= 1'b0;
        end else if (ce_w[n]) begin
          s1_ff   <= raw;
          s2_ff   <= s1_ff;
          s3_ff   <= s2_ff;
          if (s1_ff == s2_ff && s2_ff == s3_ff) begin
            flt_ff <= s3_ff;
          end
          prev_ff <= filt;
        end
      end

      assign filt = (cond == `CLB_COND_RESAMPLE) ? s2_ff :
                    (cond == `CLB_COND_FILTER)   ? flt_ff : raw;
      assign proc_w[n]  = ca[`CLB_RISE_BIT] ? (filt & ~prev_ff) : filt;
      assign en_w[n]    = en;
      assign outen_w[n] = ca[`CLB_OUTEN_BIT];
    end

    // ****************************************
    // sequencers
    // ****************************************
    for (n = 0; n < 2; n = n + 1) begin : g_seq
      wire       a    = proc_w[2*n];
      wire       b    = proc_w[2*n+1];
      wire       ce   = ce_w[2*n];
      wire [3:0] mode = seq_ff[n];
      reg        q_ff;

      always @(posedge aclk) begin
        if (!aresetn || !en_w[2*n]) begin
          q_ff <= 1'b0;
        end else begin
          case (mode)
            `CLB_SEQ_GFLOP: begin
              if (ce && b) begin
                q_ff <= a;
              end
            end
            `CLB_SEQ_SRTFLOP: begin
              if (ce) begin
                case ({a, b})
                  2'h1:    q_ff <= 1'b0;
                  2'h2:    q_ff <= 1'b1;
                  2'h3:    q_ff <= ~q_ff;
                  default: q_ff <= q_ff;
                endcase
              end
            end
            `CLB_SEQ_GLATCH: begin
              if (b) begin
                q_ff <= a;
              end
            end
            `CLB_SEQ_SCLATCH: begin
              if (a && !b) begin
                q_ff <= 1'b1;
              end else if (b && !a) begin
                q_ff <= 1'b0;
              end
            end
            default: q_ff <= 1'b0;
          endcase
        end
      end

      // disable clears the output at once, not at the next edge
      assign seq_w[n] = q_ff & en_w[2*n];
    end
  endgenerate

  // ****************************************
  // output stage
  // ****************************************
  always @* begin
    for (i = 0; i < 4; i = i + 1) begin
      if (i % 2 == 0 && seq_ff[i/2] != `CLB_SEQ_OFF) begin
        out_w[i] = seq_w[i/2];
      end else begin
        out_w[i] = en_w[i] & proc_w[i];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      direct_ff  <= 4'h0;
      lut_out_ff <= 4'h0;
    end else begin
      direct_ff  <= out_w;
      lut_out_ff <= out_w & outen_w;
    end
  end

endmodule

// *** rtl/clb_defines.vh ***
`ifndef CLB_DEFINES_VH
`define CLB_DEFINES_VH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define CLB_IDX_GLOBAL    6'h00
`define CLB_IDX_SEQ0      6'h01
`define CLB_IDX_SEQ1      6'h02
`define CLB_IDX_LUT_BASE  6'h08
`define CLB_IDX_LUT_END   6'h17
`define CLB_IDX_STATUS    6'h18

// ****************************************
// field positions
// ****************************************
`define CLB_EN_BIT        0
`define CLB_RUNSTDBY_BIT  6
`define CLB_CLKSEL_HI     3
`define CLB_CLKSEL_LO     1
`define CLB_COND_HI       5
`define CLB_COND_LO       4
`define CLB_OUTEN_BIT     6
`define CLB_RISE_BIT      7
`define CLB_GLOBAL_MASK   8'h41

// ****************************************
// reset values
// ****************************************
`define CLB_RST_BYTE      8'h00
`define CLB_RST_NIBBLE    4'h0

// ****************************************
// encodings
// ****************************************
`define CLB_IN_MASK       4'h0
`define CLB_IN_FEEDBACK   4'h1
`define CLB_IN_LINK       4'h2
`define CLB_IN_EVENT_A    4'h3
`define CLB_IN_EVENT_B    4'h4
`define CLB_IN_PIN        4'h5
`define CLB_IN_AC         4'h6
`define CLB_IN_USART      4'h8
`define CLB_IN_SPI        4'h9
`define CLB_IN_TCA        4'ha
`define CLB_IN_TCB        4'hc
`define CLB_COND_NONE     2'h0
`define CLB_COND_RESAMPLE 2'h1
`define CLB_COND_FILTER   2'h2
`define CLB_CLK_INPUT_TWO 3'h1
`define CLB_SEQ_OFF       4'h0
`define CLB_SEQ_GFLOP     4'h1
`define CLB_SEQ_SRTFLOP   4'h2
`define CLB_SEQ_GLATCH    4'h3
`define CLB_SEQ_SCLATCH   4'h4
`define CLB_RESP_OKAY     2'h0
`define CLB_RESP_SLVERR   2'h2

`endif

// *** testbench/clb_core_assertions.sv ***
`timescale 1ns/10ps
module clb_chk (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awready,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire [7:0]  s_axi_araddr,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire [3:0]  lut_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_w_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");
  a_r_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read channel ready while data pending");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_b_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write channel not freed after response");
  a_r_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed after data");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h05
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_rdata_top: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_reset_quiet: assert property ($rose(aresetn) |-> lut_out == 4'h0 && !s_axi_bvalid)
    else $error("outputs not quiet after reset");
endmodule

bind clb_core clb_chk i_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .lut_out(lut_out));

// *** testbench/clb_far_side.sv ***
`timescale 1ns/10ps
module clb_far_side (
  input  wire        aclk,
  input  wire [11:0] pin_cmd,
  input  wire [7:0]  ev_cmd,
  input  wire [9:0]  per_cmd,
  output reg  [11:0] pin_ff,
  output reg  [7:0]  ev_ff,
  output reg  [9:0]  per_ff
);
  // levels change just after the clock edge, like real pins
  always @(posedge aclk) begin
    pin_ff <= pin_cmd;
    ev_ff  <= ev_cmd;
    per_ff <= per_cmd;
  end
endmodule

// *** testbench/tb_configurable_lut_logic.sv ***
`timescale 1ns/10ps
module tb_configurable_lut_logic;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, jq;
  logic [7:0]  awaddr, araddr, p, q;
  logic [31:0] wdata;
  wire         awready, wready, bvalid, arready, rvalid;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  lut_out;
  logic [11:0] pin_cmd;
  logic [7:0]  ev_cmd;
  logic [9:0]  per_cmd;
  wire  [11:0] pins;
  wire  [7:0]  evs;
  wire  [9:0]  pers;
  logic [15:0] lfsr_ff;
  logic [7:0]  mdl [64];
  int          err_total, checks, i;
  int          probe [8] = '{0, 1, 2, 8, 9, 10, 11, 5};
  bit          jv [7] = '{1, 0, 0, 1, 1, 1, 0};
  bit          kv [7] = '{0, 0, 1, 0, 1, 0, 0};

  always #10 aclk = ~aclk;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic int er(input int x);
    return (x < 3 || (x >= 8 && x < 25)) ? 0 : 2;
  endfunction
  always @(posedge aclk) begin
    lfsr_ff <= lfsr(lfsr_ff);
    per_cmd <= lfsr_ff[9:0];
  end

  clb_far_side i_far (.aclk(aclk), .pin_cmd(pin_cmd), .ev_cmd(ev_cmd), .per_cmd(per_cmd),
    .pin_ff(pins), .ev_ff(evs), .per_ff(pers));
  clb_core i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .lut_pin_in(pins), .event_a(evs[3:0]), .event_b(evs[7:4]),
    .ac_out(pers[0]), .usart_txd(pers[2:1]), .spi_mosi(pers[3]), .spi_sck(pers[4]),
    .tca_wo(pers[7:5]), .tcb_wo(pers[9:8]), .lut_out(lut_out));

  // ****************************************
  // reporting and bus tasks
  // ****************************************
  task final_report;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task hang;
    err_total++;
    $display("MISMATCH timeout expected 1 seen 0");
    final_report;
  endtask
  task automatic wr(input logic [5:0] x, input logic [7:0] d, output logic [1:0] r);
    int n;
    // one edge between transfers so bready is never assigned twice in a step
    @(posedge aclk);
    awaddr <= {x, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 40) hang;
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [5:0] x, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= {x, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 40) hang;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // register model: protection follows the pair's even table enable
  task automatic wreg(input int x, input logic [7:0] d);
    int ev;
    logic [1:0] r;
    ev = (x == 1 || x == 2) ? 8 * x : (x >= 8 && x < 24) ? 8 + 8 * ((x - 8) / 8) : -1;
    if (ev >= 0 && mdl[ev][0]) begin
      if (x % 4 == 0) mdl[x][0] = d[0];
    end else if (ev >= 0 || x == 0) begin
      mdl[x] = d & ((x == 0) ? 8'h41 : (x < 3 || x % 4 == 2) ? 8'h0f : 8'hff);
    end
    wr(x[5:0], d, r);
    chk("bresp", er(x), r);
  endtask
  task automatic rreg(input int x);
    logic [31:0] d;
    logic [1:0] r;
    rdr(x[5:0], d, r);
    chk("rdata", mdl[x], d);
    chk("rresp", er(x), r);
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (50000) @(posedge aclk);
    hang;
  end
  initial begin
    aclk = 0; aresetn = 0; awaddr = 0; araddr = 0; wdata = 0; awvalid = 0; wvalid = 0;
    bready = 0; arvalid = 0; rready = 0; pin_cmd = 0; ev_cmd = 0; per_cmd = 0;
    lfsr_ff = 16'd35513; err_total = 0; checks = 0; jq = 0;
    foreach (mdl[k]) mdl[k] = 8'h00;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (probe[k]) rreg(probe[k]);
    wreg(7, 8'hff);
    $display("test reset and map done");
    wreg(0, 8'h01);
    p = lfsr_ff[7:0];
    wreg(9, 8'h55); wreg(10, 8'h05); wreg(11, p); wreg(8, 8'h41);
    for (i = 0; i < 8; i++) begin
      pin_cmd[2:0] <= i[2:0];
      wait_n(6);
      chk("lut0", p[i], lut_out[0]);
    end
    wreg(11, ~p); rreg(11);
    wreg(1, 8'h03); rreg(1);
    wreg(8, 8'h70); rreg(8);
    wait_n(4);
    chk("lut0 off", 0, lut_out[0]);
    wreg(11, ~p); rreg(11);
    $display("test truth and protection done");
    q = lfsr_ff[7:0];
    wreg(13, 8'h30); wreg(14, 8'h00); wreg(15, q); wreg(12, 8'h41);
    for (i = 0; i < 2; i++) begin
      ev_cmd[1] <= i[0];
      wait_n(6);
      chk("lut1", q[2 * i], lut_out[1]);
    end
    wreg(0, 8'h00);
    wait_n(4);
    chk("all off", 0, lut_out);
    $display("test inputs and global done");
    pin_cmd <= 12'h000;
    wreg(0, 8'h01); wreg(12, 8'h00); wreg(1, 8'h02);
    wreg(9, 8'h05); wreg(10, 8'h00); wreg(11, 8'haa);
    wreg(13, 8'h05); wreg(14, 8'h00); wreg(15, 8'haa); wreg(12, 8'h41); wreg(8, 8'h41);
    for (i = 0; i < 7; i++) begin
      pin_cmd[0] <= jv[i];
      pin_cmd[3] <= kv[i];
      if (jv[i] && kv[i]) begin
        @(posedge aclk);
        pin_cmd <= 12'h000;
      end
      jq = (jv[i] && kv[i]) ? ~jq : jv[i] ? 1'b1 : kv[i] ? 1'b0 : jq;
      wait_n(8);
      chk("seq q", jq, lut_out[0]);
    end
    wreg(8, 8'h00); wreg(8, 8'h41);
    wait_n(6);
    chk("seq cleared", 0, lut_out[0]);
    $display("test sequencer done");
    wreg(21, 8'h05); wreg(22, 8'h00); wreg(23, 8'haa); wreg(20, 8'h41);
    wreg(17, 8'h02); wreg(18, 8'h00); wreg(19, 8'haa); wreg(16, 8'h51);
    wait_n(6);
    pin_cmd[9] <= 1'b1;
    wait_n(7);
    chk("lut3 pin", 1, lut_out[3]);
    chk("lut2 resample", 0, lut_out[2]);
    @(posedge aclk);
    chk("lut2 link", 1, lut_out[2]);
    $display("test link and resample done");
    final_report;
  end
endmodule
